// File: src/alcu_regs.vh
// Constants of the arithmetic, logic and compare unit: APB register map,
// command field layout, operation and mode codes, flags and constants.
// Assumes it is included by the unit's design files and by its simulation files.
`ifndef ALCU_REGS_VH
`define ALCU_REGS_VH

// Register byte offsets on the APB, one aligned 32-bit word each.
`define ALCU_OFS_CMD 8'h00
`define ALCU_OFS_STATUS 8'h04
`define ALCU_OFS_ACC 8'h08
`define ALCU_OFS_FLAGS 8'h0C
`define ALCU_OFS_PTR_X 8'h10
`define ALCU_OFS_PTR_Y 8'h14
`define ALCU_OFS_PTR_U 8'h18
`define ALCU_OFS_IMM 8'h1C
`define ALCU_OFS_ABS 8'h20

// Command word layout.
`define ALCU_CMD_W 11
`define ALCU_CMD_OP_MSB 4
`define ALCU_CMD_OP_LSB 0
`define ALCU_CMD_MODE_MSB 7
`define ALCU_CMD_MODE_LSB 5
`define ALCU_CMD_SEL_MSB 9
`define ALCU_CMD_SEL_LSB 8
`define ALCU_CMD_SPACE 10

// Operation codes.
`define ALCU_OP_ADR 5'h00
`define ALCU_OP_SWB 5'h01
`define ALCU_OP_SUI 5'h02
`define ALCU_OP_DSU 5'h03
`define ALCU_OP_DAD 5'h04
`define ALCU_OP_AND 5'h05
`define ALCU_OP_AIM 5'h06
`define ALCU_OP_ORM 5'h07
`define ALCU_OP_OIM 5'h08
`define ALCU_OP_XRM 5'h09
`define ALCU_OP_XIM 5'h0A
`define ALCU_OP_INC 5'h0B
`define ALCU_OP_DEC 5'h0C
`define ALCU_OP_CMA 5'h0D
`define ALCU_OP_CMI 5'h0E
`define ALCU_OP_BIT 5'h0F
`define ALCU_OP_TBI 5'h10

// Operand modes.
`define ALCU_MODE_ACC 3'h0
`define ALCU_MODE_LOW 3'h1
`define ALCU_MODE_HIGH 3'h2
`define ALCU_MODE_PTRMEM 3'h3
`define ALCU_MODE_ABSMEM 3'h4
`define ALCU_MODE_WIDE 3'h5

// Pointer pair select codes.
`define ALCU_SEL_X 2'h0
`define ALCU_SEL_Y 2'h1
`define ALCU_SEL_U 2'h2
`define ALCU_SEL_SPARE 2'h3

// Flag and status bit positions.
`define ALCU_FLAG_C 0
`define ALCU_FLAG_Z 1
`define ALCU_FLAG_V 2
`define ALCU_FLAG_H 3
`define ALCU_STAT_BUSY 0

// Byte and word constants.
`define ALCU_BYTE_ZERO 8'h00
`define ALCU_BYTE_ONE 8'h01
`define ALCU_BYTE_ONES 8'hFF
`define ALCU_WORD_ZERO 16'h0000
`define ALCU_WORD_ONE 16'h0001
`define ALCU_RD_ZERO 32'h0000_0000
`define ALCU_CMD_RST 11'h000

// Decimal bias and correction constants, chosen by carry and half-carry.
`define ALCU_DEC_BIAS 8'h66
`define ALCU_ADJ_NONE 8'h9A
`define ALCU_ADJ_HALF 8'hA0
`define ALCU_ADJ_CARRY 8'hF0
`define ALCU_ADJ_BOTH 8'h00

// Decimal step counter values.
`define ALCU_PH0 2'h0
`define ALCU_PH1 2'h1
`define ALCU_PH2 2'h2

`endif

// File: src/alcu_adder.v
// Eight-bit adder with carry in, giving carry, half-carry and overflow.
// Assumes a purely combinational use inside the unit's execute stage.
`timescale 1ns/1ns
module alcu_adder (
    input wire [7:0] i_a,
    input wire [7:0] i_b,
    input wire i_cin,
    output wire [7:0] o_sum,
    output wire o_c,
    output wire o_h,
    output wire o_v
);

    wire [8:0] full;
    wire [4:0] nib;

    // Full sum and low nibble sum; the nibble carry is the half-carry.
    assign full = {1'h0, i_a} + {1'h0, i_b} + {8'h00, i_cin};
    assign nib = {1'h0, i_a[3:0]} + {1'h0, i_b[3:0]} + {4'h0, i_cin};

    // Overflow when like-signed inputs give an unlike-signed sum.
    assign o_sum = full[7:0];
    assign o_c = full[8];
    assign o_h = nib[4];
    assign o_v = (i_a[7] == i_b[7]) && (full[7] != i_a[7]);

endmodule // alcu_adder

// File: src/alcu_top.v
// Arithmetic, logic, compare and bit-test unit of an 8-bit processor core,
// holding accumulator, flags and three pointer pairs behind an APB slave.
// Assumes a memory bus on the same clock that answers o_mem_req with a
// one-cycle i_mem_ack, and software that writes a command only when idle.
`timescale 1ns/1ns
`include "alcu_regs.vh"
module alcu_top (
    input wire i_mclk,
    input wire i_rst_b,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [7:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg [31:0] o_prdata,
    output wire o_pready,
    output wire o_pslverr,
    output reg o_mem_req,
    output reg o_mem_we,
    output reg [15:0] o_mem_addr,
    output reg [7:0] o_mem_wdata,
    output reg o_mem_space,
    input wire i_mem_ack,
    input wire [7:0] i_mem_rdata,
    output wire o_busy
);

    localparam ST_IDLE = 2'h0;
    localparam ST_READ = 2'h1;
    localparam ST_EXEC = 2'h2;
    localparam ST_WRITE = 2'h3;

    reg [1:0] state;
    reg [1:0] phase;
    reg [`ALCU_CMD_W-1:0] cmd;
    reg [7:0] acc;
    reg [7:0] imm;
    reg [7:0] mdata;
    reg [15:0] abs_addr;
    reg [15:0] ptr [0:2];
    reg flag_c;
    reg flag_z;
    reg flag_v;
    reg flag_h;

    reg [31:0] next_rdata;
    reg addr_hit;
    reg [7:0] tgt;
    reg [7:0] adj;
    reg [7:0] add_a;
    reg [7:0] add_b;
    reg add_cin;
    reg [7:0] next_logic;
    reg next_arith;
    reg next_zonly;
    reg next_more;
    reg next_put;
    reg [7:0] next_put_val;
    reg next_acc_set;
    reg [7:0] next_acc_in;
    reg next_ptr_set;
    reg [15:0] next_ptr_in;
    reg next_acc_we;
    reg [7:0] next_acc_val;
    reg next_ptr_we;
    reg [15:0] next_ptr_val;
    reg next_mem_we;

    wire [7:0] add_sum;
    wire add_c;
    wire add_h;
    wire add_v;
    wire apb_wr;
    wire apb_setup_rd;
    wire [4:0] op;
    wire [2:0] mode;
    wire [1:0] idx;
    wire [15:0] ptr_cur;
    wire [4:0] w_op;
    wire [2:0] w_mode;
    wire [1:0] w_idx;
    wire start_mem;

    // Operand mode actually used; two immediate forms act on A only.
    function [2:0] eff_mode;
        input [4:0] f_op;
        input [2:0] f_mode;
        begin
            if (f_op == `ALCU_OP_SUI || f_op == `ALCU_OP_XIM)
                eff_mode = `ALCU_MODE_ACC;
            else
                eff_mode = f_mode;
        end
    endfunction

    // Pair index; the spare select code falls on the third pair.
    function [1:0] pair_idx;
        input [1:0] f_sel;
        begin
            if (f_sel == `ALCU_SEL_SPARE)
                pair_idx = `ALCU_SEL_U;
            else
                pair_idx = f_sel;
        end
    endfunction

    // Decode of the latched command and of a command being written.
    assign op = cmd[`ALCU_CMD_OP_MSB:`ALCU_CMD_OP_LSB];
    assign mode = eff_mode(op, cmd[`ALCU_CMD_MODE_MSB:`ALCU_CMD_MODE_LSB]);
    assign idx = pair_idx(cmd[`ALCU_CMD_SEL_MSB:`ALCU_CMD_SEL_LSB]);
    assign ptr_cur = ptr[idx];
    assign w_op = i_pwdata[`ALCU_CMD_OP_MSB:`ALCU_CMD_OP_LSB];
    assign w_mode = eff_mode(w_op,
                             i_pwdata[`ALCU_CMD_MODE_MSB:`ALCU_CMD_MODE_LSB]);
    assign w_idx = pair_idx(i_pwdata[`ALCU_CMD_SEL_MSB:`ALCU_CMD_SEL_LSB]);
    assign start_mem = (w_mode == `ALCU_MODE_PTRMEM) ||
                       (w_mode == `ALCU_MODE_ABSMEM);

    // APB handshake: zero wait states, error on an unmapped address.
    assign apb_wr = i_psel && i_penable && i_pwrite;
    assign apb_setup_rd = i_psel && !i_penable && !i_pwrite;
    assign o_pready = 1'h1;
    assign o_pslverr = i_psel && i_penable && !addr_hit;
    assign o_busy = (state != ST_IDLE);

    // Read data selection and address decode.
    always @*
    begin
        next_rdata = `ALCU_RD_ZERO;
        addr_hit = 1'h1;
        case (i_paddr)
        `ALCU_OFS_CMD: next_rdata[`ALCU_CMD_W-1:0] = cmd;
        `ALCU_OFS_STATUS: next_rdata[`ALCU_STAT_BUSY] = o_busy;
        `ALCU_OFS_ACC: next_rdata[7:0] = acc;
        `ALCU_OFS_FLAGS:
        begin
            next_rdata[`ALCU_FLAG_C] = flag_c;
            next_rdata[`ALCU_FLAG_Z] = flag_z;
            next_rdata[`ALCU_FLAG_V] = flag_v;
            next_rdata[`ALCU_FLAG_H] = flag_h;
        end
        `ALCU_OFS_PTR_X: next_rdata[15:0] = ptr[`ALCU_SEL_X];
        `ALCU_OFS_PTR_Y: next_rdata[15:0] = ptr[`ALCU_SEL_Y];
        `ALCU_OFS_PTR_U: next_rdata[15:0] = ptr[`ALCU_SEL_U];
        `ALCU_OFS_IMM: next_rdata[7:0] = imm;
        `ALCU_OFS_ABS: next_rdata[15:0] = abs_addr;
        default: addr_hit = 1'h0;
        endcase
    end

    // Read data is captured in the setup cycle, ready for the access.
    always @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_prdata <= `ALCU_RD_ZERO;
        else if (apb_setup_rd)
            o_prdata <= next_rdata;
    end

    // Target byte named by the operand mode; memory comes from the latch.
    always @*
    begin
        case (mode)
        `ALCU_MODE_LOW: tgt = ptr_cur[7:0];
        `ALCU_MODE_HIGH: tgt = ptr_cur[15:8];
        `ALCU_MODE_PTRMEM: tgt = mdata;
        `ALCU_MODE_ABSMEM: tgt = mdata;
        default: tgt = acc;
        endcase
    end

    // Decimal correction picked from the flags of the preceding add.
    always @*
    begin
        case ({flag_c, flag_h})
        2'h0: adj = `ALCU_ADJ_NONE;
        2'h1: adj = `ALCU_ADJ_HALF;
        2'h2: adj = `ALCU_ADJ_CARRY;
        default: adj = `ALCU_ADJ_BOTH;
        endcase
    end

    // Adder inputs and logic result for the current step.
    always @*
    begin
        add_a = acc;
        add_b = ~tgt;
        add_cin = flag_c;
        next_logic = acc & tgt;
        case (op)
        `ALCU_OP_ADR:
        begin
            add_a = ptr_cur[7:0];
            add_b = acc;
            add_cin = 1'h0;
        end
        `ALCU_OP_SUI: add_b = ~imm;
        `ALCU_OP_DSU:
        begin
            if (phase != `ALCU_PH0)
            begin
                add_b = adj;
                add_cin = 1'h0;
            end
        end
        `ALCU_OP_DAD:
        begin
            add_cin = 1'h0;
            add_b = adj;
            if (phase == `ALCU_PH0)
                add_b = `ALCU_DEC_BIAS;
            else if (phase == `ALCU_PH1)
            begin
                add_b = tgt;
                add_cin = flag_c;
            end
        end
        `ALCU_OP_INC:
        begin
            add_a = tgt;
            add_b = `ALCU_BYTE_ZERO;
            add_cin = 1'h1;
        end
        `ALCU_OP_DEC:
        begin
            add_a = tgt;
            add_b = `ALCU_BYTE_ONES;
            add_cin = 1'h0;
        end
        `ALCU_OP_CMA: add_cin = 1'h1;
        `ALCU_OP_CMI:
        begin
            add_a = tgt;
            add_b = ~imm;
            add_cin = 1'h1;
        end
        `ALCU_OP_AIM: next_logic = tgt & imm;
        `ALCU_OP_ORM: next_logic = acc | tgt;
        `ALCU_OP_OIM: next_logic = tgt | imm;
        `ALCU_OP_XRM: next_logic = acc ^ tgt;
        `ALCU_OP_XIM: next_logic = acc ^ imm;
        `ALCU_OP_TBI: next_logic = tgt & imm;
        default: next_logic = acc & tgt;
        endcase
    end

    alcu_adder u_adder (
        .i_a(add_a),
        .i_b(add_b),
        .i_cin(add_cin),
        .o_sum(add_sum),
        .o_c(add_c),
        .o_h(add_h),
        .o_v(add_v)
    );

    // Effects of the current step: flags, destination and further steps.
    always @*
    begin
        next_arith = 1'h0;
        next_zonly = 1'h0;
        next_more = 1'h0;
        next_put = 1'h0;
        next_put_val = add_sum;
        next_acc_set = 1'h0;
        next_acc_in = add_sum;
        next_ptr_set = 1'h0;
        next_ptr_in = ptr_cur;
        case (op)
        `ALCU_OP_ADR:
        begin
            next_arith = 1'h1;
            next_ptr_set = 1'h1;
            next_ptr_in = {ptr_cur[15:8] +
                           (add_c ? `ALCU_BYTE_ONE : `ALCU_BYTE_ZERO),
                           add_sum};
        end
        `ALCU_OP_SWB, `ALCU_OP_SUI:
        begin
            next_arith = 1'h1;
            next_acc_set = 1'h1;
        end
        `ALCU_OP_DSU:
        begin
            next_acc_set = 1'h1;
            next_arith = (phase == `ALCU_PH0);
            next_more = (phase == `ALCU_PH0);
        end
        `ALCU_OP_DAD:
        begin
            next_acc_set = 1'h1;
            next_arith = (phase == `ALCU_PH1);
            next_more = (phase != `ALCU_PH2);
        end
        `ALCU_OP_AND, `ALCU_OP_ORM, `ALCU_OP_XRM, `ALCU_OP_XIM:
        begin
            next_zonly = 1'h1;
            next_acc_set = 1'h1;
            next_acc_in = next_logic;
        end
        `ALCU_OP_AIM, `ALCU_OP_OIM:
        begin
            next_zonly = 1'h1;
            next_put = 1'h1;
            next_put_val = next_logic;
        end
        `ALCU_OP_INC, `ALCU_OP_DEC:
        begin
            if (mode == `ALCU_MODE_WIDE)
            begin
                next_ptr_set = 1'h1;
                if (op == `ALCU_OP_INC)
                    next_ptr_in = ptr_cur + `ALCU_WORD_ONE;
                else
                    next_ptr_in = ptr_cur - `ALCU_WORD_ONE;
            end
            else
            begin
                next_arith = 1'h1;
                next_put = 1'h1;
            end
        end
        `ALCU_OP_CMA, `ALCU_OP_CMI: next_arith = 1'h1;
        `ALCU_OP_BIT, `ALCU_OP_TBI: next_zonly = 1'h1;
        default: next_more = 1'h0;
        endcase
    end

    // Routing of a target write to the accumulator, a pair or memory.
    always @*
    begin
        next_acc_we = next_acc_set;
        next_acc_val = next_acc_in;
        next_ptr_we = next_ptr_set;
        next_ptr_val = next_ptr_in;
        next_mem_we = 1'h0;
        if (next_put)
        begin
            case (mode)
            `ALCU_MODE_ACC:
            begin
                next_acc_we = 1'h1;
                next_acc_val = next_put_val;
            end
            `ALCU_MODE_LOW:
            begin
                next_ptr_we = 1'h1;
                next_ptr_val = {ptr_cur[15:8], next_put_val};
            end
            `ALCU_MODE_HIGH:
            begin
                next_ptr_we = 1'h1;
                next_ptr_val = {next_put_val, ptr_cur[7:0]};
            end
            `ALCU_MODE_PTRMEM, `ALCU_MODE_ABSMEM:
                next_mem_we = 1'h1;
            default: next_mem_we = 1'h0;
            endcase
        end
    end

    // Sequencer: software access when idle, memory read, steps, write.
    always @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state <= ST_IDLE;
            phase <= `ALCU_PH0;
            cmd <= `ALCU_CMD_RST;
            acc <= `ALCU_BYTE_ZERO;
            imm <= `ALCU_BYTE_ZERO;
            mdata <= `ALCU_BYTE_ZERO;
            abs_addr <= `ALCU_WORD_ZERO;
            ptr[`ALCU_SEL_X] <= `ALCU_WORD_ZERO;
            ptr[`ALCU_SEL_Y] <= `ALCU_WORD_ZERO;
            ptr[`ALCU_SEL_U] <= `ALCU_WORD_ZERO;
            flag_c <= 1'h0;
            flag_z <= 1'h0;
            flag_v <= 1'h0;
            flag_h <= 1'h0;
            o_mem_req <= 1'h0;
            o_mem_we <= 1'h0;
            o_mem_addr <= `ALCU_WORD_ZERO;
            o_mem_wdata <= `ALCU_BYTE_ZERO;
            o_mem_space <= 1'h0;
        end
        else
        begin
            case (state)
            ST_IDLE:
            begin
                if (apb_wr)
                begin
                    case (i_paddr)
                    `ALCU_OFS_CMD:
                    begin
                        cmd <= i_pwdata[`ALCU_CMD_W-1:0];
                        phase <= `ALCU_PH0;
                        o_mem_space <= i_pwdata[`ALCU_CMD_SPACE];
                        if (w_mode == `ALCU_MODE_PTRMEM)
                            o_mem_addr <= ptr[w_idx];
                        else
                            o_mem_addr <= abs_addr;
                        o_mem_req <= start_mem;
                        o_mem_we <= 1'h0;
                        state <= start_mem ? ST_READ : ST_EXEC;
                    end
                    `ALCU_OFS_ACC: acc <= i_pwdata[7:0];
                    `ALCU_OFS_FLAGS:
                    begin
                        flag_c <= i_pwdata[`ALCU_FLAG_C];
                        flag_z <= i_pwdata[`ALCU_FLAG_Z];
                        flag_v <= i_pwdata[`ALCU_FLAG_V];
                        flag_h <= i_pwdata[`ALCU_FLAG_H];
                    end
                    `ALCU_OFS_PTR_X: ptr[`ALCU_SEL_X] <= i_pwdata[15:0];
                    `ALCU_OFS_PTR_Y: ptr[`ALCU_SEL_Y] <= i_pwdata[15:0];
                    `ALCU_OFS_PTR_U: ptr[`ALCU_SEL_U] <= i_pwdata[15:0];
                    `ALCU_OFS_IMM: imm <= i_pwdata[7:0];
                    `ALCU_OFS_ABS: abs_addr <= i_pwdata[15:0];
                    default: state <= ST_IDLE;
                    endcase
                end
            end
            ST_READ:
            begin
                if (i_mem_ack)
                begin
                    mdata <= i_mem_rdata;
                    o_mem_req <= 1'h0;
                    state <= ST_EXEC;
                end
            end
            ST_EXEC:
            begin
                if (next_arith)
                begin
                    flag_c <= add_c;
                    flag_h <= add_h;
                    flag_v <= add_v;
                    flag_z <= (add_sum == `ALCU_BYTE_ZERO);
                end
                if (next_zonly)
                    flag_z <= (next_logic == `ALCU_BYTE_ZERO);
                if (next_acc_we)
                    acc <= next_acc_val;
                if (next_ptr_we)
                    ptr[idx] <= next_ptr_val;
                if (next_more)
                    phase <= phase + `ALCU_PH1;
                else if (next_mem_we)
                begin
                    o_mem_wdata <= next_put_val;
                    o_mem_we <= 1'h1;
                    o_mem_req <= 1'h1;
                    state <= ST_WRITE;
                end
                else
                    state <= ST_IDLE;
            end
            ST_WRITE:
            begin
                if (i_mem_ack)
                begin
                    o_mem_req <= 1'h0;
                    o_mem_we <= 1'h0;
                    state <= ST_IDLE;
                end
            end
            default: state <= ST_IDLE;
            endcase
        end
    end

endmodule // alcu_top

// File: sim/alcu_assertions.sv
// Port timing checker for the arithmetic, logic and compare unit.
// Assumes it is bound to alcu_top and sees only that module's ports.
`timescale 1ns/1ns
`include "alcu_regs.vh"
module alcu_assertions (
    input wire i_mclk,
    input wire i_rst_b,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [7:0] i_paddr,
    input wire [31:0] i_pwdata,
    input wire [31:0] o_prdata,
    input wire o_pready,
    input wire o_pslverr,
    input wire o_mem_req,
    input wire o_mem_we,
    input wire [15:0] o_mem_addr,
    input wire [7:0] o_mem_wdata,
    input wire o_mem_space,
    input wire i_mem_ack,
    input wire [7:0] i_mem_rdata,
    input wire o_busy
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_b);
    wire cmd_wr;
    reg [4:0] op;
    reg space;
    reg [15:0] rd_addr;
    // A command is taken only when the unit is idle.
    assign cmd_wr = i_psel && i_penable && i_pwrite && !o_busy
        && i_paddr == `ALCU_OFS_CMD;
    // Keeps the last command taken and the last address read.
    always @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            op <= 5'h00;
            space <= 1'b0;
            rd_addr <= 16'h0000;
        end
        else
        begin
            if (cmd_wr)
                op <= i_pwdata[4:0];
            if (cmd_wr)
                space <= i_pwdata[10];
            if (o_mem_req && i_mem_ack && !o_mem_we)
                rd_addr <= o_mem_addr;
        end
    end
    inc_time_a: assert property (cmd_wr && i_pwdata[7:0] == 8'h0B
        |=> o_busy ##1 !o_busy) else $error("increment timing wrong");
    dadd_time_a: assert property (cmd_wr && i_pwdata[7:0] == 8'h24
        |=> o_busy [*3] ##1 !o_busy) else $error("decimal add timing");
    space_sel_a: assert property ($rose(o_mem_req)
        |-> o_mem_space == space) else $error("wrong memory space");
    rmw_addr_a: assert property (o_mem_req && o_mem_we
        |-> o_mem_addr == rd_addr) else $error("write address moved");
    no_write_a: assert property (o_mem_req && o_mem_we
        |-> !(op inside {`ALCU_OP_BIT, `ALCU_OP_TBI, `ALCU_OP_CMA,
        `ALCU_OP_AND, `ALCU_OP_ORM, `ALCU_OP_XRM}))
        else $error("memory written by a read-only command");
    req_hold_a: assert property (o_mem_req && !i_mem_ack
        |=> o_mem_req && $stable(o_mem_addr) && $stable(o_mem_we))
        else $error("memory request changed before ack");
    req_drop_a: assert property (o_mem_req && i_mem_ack
        |=> !o_mem_req) else $error("memory request held after ack");
    unmap_err_a: assert property (i_psel && i_penable && i_paddr == 8'h40
        |-> o_pslverr && (i_pwrite || o_prdata == 32'h0000_0000))
        else $error("unmapped access not refused");
    cover property (o_mem_req && o_mem_we && i_mem_ack);
    cover property (cmd_wr);
    cover property (o_pslverr);
endmodule // alcu_assertions
bind alcu_top alcu_assertions chk (.*);

// File: sim/alcu_mem_model.sv
// Byte memory behind the unit's memory port, two spaces of 256 bytes.
// Assumes requests stand until ack; i_lat sets the answer delay.
`timescale 1ns/1ns
module alcu_mem_model (
    input wire i_mclk,
    input wire i_req,
    input wire i_we,
    input wire [15:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_space,
    input wire [3:0] i_lat,
    output reg o_ack,
    output reg [7:0] o_rdata
);
    reg [7:0] mem [0:511];
    reg [3:0] cnt;
    wire [8:0] idx;
    assign idx = {i_space, i_addr[7:0]};
    initial
    begin
        o_ack = 1'b0;
        o_rdata = 8'h00;
        cnt = 4'h0;
    end
    // Read data is valid only in the ack cycle and toggles otherwise.
    always @(posedge i_mclk)
    begin
        o_ack <= 1'b0;
        o_rdata <= ~o_rdata;
        if (o_ack && i_we)
            mem[idx] <= i_wdata;
        if (o_ack || !i_req)
            cnt <= 4'h0;
        else if (cnt < i_lat)
            cnt <= cnt + 4'h1;
        else
        begin
            o_ack <= 1'b1;
            o_rdata <= mem[idx];
        end
    end
endmodule // alcu_mem_model

// File: sim/tb_top.sv
// Self-checking bench: runs each command over APB and checks results.
// Assumes the unit and the memory model share the 10 MHz clock.
`timescale 1ns/1ns
`include "alcu_regs.vh"
module tb_top;
    reg i_mclk, i_rst_b, i_psel, i_penable, i_pwrite;
    reg [7:0] i_paddr;
    reg [31:0] i_pwdata;
    reg [3:0] lat;
    wire [31:0] o_prdata;
    wire o_pready, o_pslverr, o_mem_req, o_mem_we, o_mem_space;
    wire [15:0] o_mem_addr;
    wire [7:0] o_mem_wdata, i_mem_rdata;
    wire o_busy, i_mem_ack;
    integer error_cnt, checked;
    alcu_top uut (.*);
    alcu_mem_model m (.i_mclk(i_mclk), .i_req(o_mem_req),
        .i_we(o_mem_we), .i_addr(o_mem_addr), .i_wdata(o_mem_wdata),
        .i_space(o_mem_space), .i_lat(lat), .o_ack(i_mem_ack),
        .o_rdata(i_mem_rdata));
    // Free-running clock of 100 ns period.
    initial
    begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end
    task give_verdict;
    begin
        if (error_cnt == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask
    task cmp(input string nm, input [31:0] e, input [31:0] g);
    begin
        checked = checked + 1;
        if (g !== e)
        begin
            error_cnt = error_cnt + 1;
            $display("MISMATCH %0s exp %h got %h", nm, e, g);
        end
    end
    endtask
    // One APB transfer: setup, access until pready, then one idle cycle.
    task bus(input [7:0] a, input w, input [31:0] d, output [31:0] q);
        integer n;
    begin
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_mclk);
        i_penable <= 1'b1;
        n = 0;
        @(posedge i_mclk);
        while (o_pready !== 1'b1 && n < 20)
        begin
            n = n + 1;
            @(posedge i_mclk);
        end
        if (o_pready !== 1'b1)
            error_cnt = error_cnt + 1;
        if (o_pready !== 1'b1)
            give_verdict;
        q = o_prdata;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_mclk);
    end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        reg [31:0] q;
        bus(a, 1'b1, d, q);
    endtask
    task rdc(input string nm, input [7:0] a, input [31:0] e);
        reg [31:0] q;
    begin
        bus(a, 1'b0, 32'h0000_0000, q);
        cmp(nm, e, q);
    end
    endtask
    // Loads operands on pair U, runs a command, checks A, flags, memory.
    task dop(input [4:0] op, input [2:0] md, input sp, input [7:0] a,
        input [7:0] b, input [3:0] f, input [7:0] ea, input [3:0] ef,
        input [7:0] em);
        integer n;
        reg [31:0] q;
    begin
        m.mem[{sp, b}] = b;
        m.mem[{~sp, b}] = ~b;
        wr(`ALCU_OFS_ACC, {24'h00_0000, a});
        wr(`ALCU_OFS_FLAGS, {28'h000_0000, f});
        wr(`ALCU_OFS_PTR_U, {16'h0000, 8'h40, b});
        wr(`ALCU_OFS_ABS, {16'h0000, 8'h40, b});
        wr(`ALCU_OFS_CMD, {21'h00_0000, sp, 2'h2, md, op});
        n = 0;
        q = 32'h0000_0001;
        while (q[0] !== 1'b0 && n < 40)
        begin
            n = n + 1;
            bus(`ALCU_OFS_STATUS, 1'b0, 32'h0000_0000, q);
        end
        cmp("busy", 32'h0000_0000, q);
        if (q[0] !== 1'b0)
            give_verdict;
        rdc("acc", `ALCU_OFS_ACC, {24'h00_0000, ea});
        rdc("flags", `ALCU_OFS_FLAGS, {28'h000_0000, ef});
        cmp("mem", {24'h00_0000, em}, {24'h00_0000, m.mem[{sp, b}]});
    end
    endtask
    // Main sequence: reset for 16 cycles, then every command kind.
    initial
    begin
        {i_rst_b, i_psel, i_penable, i_pwrite} = 4'h0;
        i_paddr = 8'h00;
        i_pwdata = 32'h0000_0000;
        lat = 4'h0;
        error_cnt = 0;
        checked = 0;
        repeat (16) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        @(posedge i_mclk);
        wr(`ALCU_OFS_IMM, 32'h0000_000F);
        dop(`ALCU_OP_ADR,3'h1,0,8'h80,8'h90,4'h0,8'h80,4'h5,8'h90);
        rdc("ptr_u", `ALCU_OFS_PTR_U, 32'h0000_4110);
        dop(`ALCU_OP_SWB,3'h1,0,8'h38,8'h21,4'h1,8'h17,4'h9,8'h21);
        dop(`ALCU_OP_SUI,3'h1,0,8'h24,8'h55,4'h0,8'h14,4'h1,8'h55);
        dop(`ALCU_OP_DSU,3'h3,0,8'h42,8'h31,4'h1,8'h11,4'h9,8'h31);
        dop(`ALCU_OP_DSU,3'h3,1,8'h23,8'h54,4'h0,8'h68,4'h0,8'h54);
        dop(`ALCU_OP_DSU,3'h1,0,8'h41,8'h32,4'h1,8'hFF,4'h1,8'h32);
        dop(`ALCU_OP_DSU,3'h1,0,8'h32,8'h41,4'h1,8'h91,4'h8,8'h41);
        dop(`ALCU_OP_DAD,3'h3,1,8'h35,8'h27,4'h0,8'h62,4'h8,8'h27);
        dop(`ALCU_OP_DAD,3'h1,0,8'h35,8'h67,4'h1,8'h03,4'h9,8'h67);
        dop(`ALCU_OP_AND,3'h3,0,8'hD4,8'h6C,4'hF,8'h44,4'hD,8'h6C);
        lat <= 4'h3;
        dop(`ALCU_OP_AIM,3'h3,1,8'h5A,8'h3C,4'h0,8'h5A,4'h0,8'h0C);
        dop(`ALCU_OP_AIM,3'h0,0,8'hF0,8'h22,4'h0,8'h00,4'h2,8'h22);
        dop(`ALCU_OP_ORM,3'h4,0,8'h58,8'h27,4'hF,8'h7F,4'hD,8'h27);
        dop(`ALCU_OP_OIM,3'h4,1,8'h11,8'h30,4'h2,8'h11,4'h0,8'h3F);
        dop(`ALCU_OP_XRM,3'h3,0,8'h36,8'h6D,4'h0,8'h5B,4'h0,8'h6D);
        dop(`ALCU_OP_XIM,3'h3,0,8'h0F,8'h77,4'h1,8'h00,4'h3,8'h77);
        dop(`ALCU_OP_INC,3'h0,0,8'hFF,8'h01,4'h0,8'h00,4'hB,8'h01);
        dop(`ALCU_OP_INC,3'h1,0,8'h11,8'h7F,4'h0,8'h11,4'hC,8'h7F);
        rdc("ptr_u", `ALCU_OFS_PTR_U, 32'h0000_4080);
        dop(`ALCU_OP_INC,3'h5,0,8'h11,8'hFF,4'hF,8'h11,4'hF,8'hFF);
        rdc("ptr_u", `ALCU_OFS_PTR_U, 32'h0000_4100);
        dop(`ALCU_OP_DEC,3'h2,0,8'h11,8'h12,4'h0,8'h11,4'h1,8'h12);
        rdc("ptr_u", `ALCU_OFS_PTR_U, 32'h0000_3F12);
        dop(`ALCU_OP_DEC,3'h5,0,8'h11,8'h00,4'h0,8'h11,4'h0,8'h00);
        rdc("ptr_u", `ALCU_OFS_PTR_U, 32'h0000_3FFF);
        dop(`ALCU_OP_CMA,3'h3,0,8'h54,8'h50,4'h0,8'h54,4'h9,8'h50);
        dop(`ALCU_OP_CMA,3'h3,1,8'h50,8'h50,4'h0,8'h50,4'hB,8'h50);
        dop(`ALCU_OP_CMA,3'h3,0,8'h50,8'h54,4'h0,8'h50,4'h0,8'h54);
        dop(`ALCU_OP_CMI,3'h2,0,8'h22,8'h33,4'h0,8'h22,4'h1,8'h33);
        dop(`ALCU_OP_CMI,3'h0,0,8'h0F,8'h33,4'h0,8'h0F,4'hB,8'h33);
        dop(`ALCU_OP_CMI,3'h1,0,8'h22,8'h0E,4'h0,8'h22,4'h0,8'h0E);
        dop(`ALCU_OP_BIT,3'h3,1,8'h80,8'h0F,4'h1,8'h80,4'h3,8'h0F);
        dop(`ALCU_OP_TBI,3'h3,0,8'h33,8'hF0,4'h0,8'h33,4'h2,8'hF0);
        // Pairs X and Y: whole-pair and low-byte increments, one cycle each.
        wr(`ALCU_OFS_PTR_X, 32'h0000_12FF);
        wr(`ALCU_OFS_CMD, 32'h0000_00AB);
        rdc("ptr_x", `ALCU_OFS_PTR_X, 32'h0000_1300);
        wr(`ALCU_OFS_PTR_Y, 32'h0000_0080);
        wr(`ALCU_OFS_CMD, 32'h0000_012B);
        rdc("ptr_y", `ALCU_OFS_PTR_Y, 32'h0000_0081);
        rdc("flags", `ALCU_OFS_FLAGS, 32'h0000_0000);
        rdc("unmapped", 8'h40, 32'h0000_0000);
        give_verdict;
    end
endmodule // tb_top
